//--- hdl/ictl_pkg.sv
package ictl_pkg;

  // Source layout: external lines first, then peripheral requests.
  localparam int unsigned NUM_SRC   = 16;
  localparam int unsigned NUM_EXT   = 3;
  localparam int unsigned NUM_PER   = NUM_SRC - NUM_EXT;
  localparam int unsigned NUM_TRAP  = 4;
  localparam int unsigned NUM_PREG  = 4;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned PRIO_W    = 3;
  localparam int unsigned LVL_W     = 4;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned REG_W     = 16;

  typedef logic [PRIO_W-1:0] ictl_prio_t;
  typedef logic [LVL_W-1:0]  ictl_lvl_t;

  // Byte addresses of the register words.
  localparam logic [ADDR_W-1:0] OFF_CTL_ONE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTL_TWO   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTL_THREE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTL_FOUR  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_VEC_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CORE_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CORE_CTL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_REQ_FLAG  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ENABLE    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PRIO0     = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_STEP      = 8'h04;

  // Field positions.
  localparam int unsigned POS_NEST_DIS  = 15;
  localparam int unsigned POS_GLB_EN    = 15;
  localparam int unsigned POS_DMA_ERR   = 5;
  localparam int unsigned POS_LOOP_OVF  = 4;
  localparam int unsigned POS_HARD_TRAP = 0;
  localparam int unsigned POS_CORE_LVL  = 5;
  localparam int unsigned POS_CORE_MSB  = 3;
  localparam int unsigned POS_NEW_LVL   = 8;
  localparam int unsigned PRIO_STRIDE   = 4;
  localparam int unsigned SRC_PER_PREG  = 4;

  // Writable masks, values after reset, nesting ceiling and vector base.
  localparam logic [REG_W-1:0] MASK_PRIO    = 16'h7777;
  localparam logic [REG_W-1:0] MASK_THREE   = 16'h0030;
  localparam logic               RST_GLB_EN   = 1'b1;
  localparam logic [REG_W-1:0] RST_ZERO     = 16'h0000;
  localparam ictl_prio_t         RST_PRIO     = 3'h4;
  localparam ictl_prio_t         LVL_NEST_MAX = 3'h7;
  localparam logic [7:0]         VEC_BASE     = 8'h08;

endpackage

//--- hdl/ictl_arb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ictl_arb_if;
  import ictl_pkg::*;
  logic [NUM_SRC-1:0]  active;
  ictl_prio_t          prio [NUM_SRC];
  ictl_lvl_t           core_lvl;
  logic                valid;
  logic [IDX_W-1:0]    index;
  ictl_prio_t          win_prio;

  modport ctrl (output active, prio, core_lvl,
                input  valid, index, win_prio);
  modport arb  (input  active, prio, core_lvl,
                output valid, index, win_prio);
endinterface
`default_nettype wire

//--- hdl/ictl_edge.sv
`timescale 1ns/1ns
`default_nettype none
module ictl_edge (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Line and its sense
  input  wire logic pin,
  input  wire logic falling,
  // Request pulse
  output logic      pulse
);
  logic prev;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= pin;
    end
  end

  assign pulse = falling ? (prev & ~pin) : (~prev & pin);
endmodule // ictl_edge
`default_nettype wire

//--- hdl/ictl_arb.sv
`timescale 1ns/1ns
`default_nettype none
module ictl_arb (
  ictl_arb_if.arb arb
);
  import ictl_pkg::*;

  // Scanning downward with >= lets the lowest vector win a tie.
  always_comb begin
    arb.valid    = 1'b0;
    arb.index    = '0;
    arb.win_prio = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (arb.active[i] && ({1'b0, arb.prio[i]} > arb.core_lvl) &&
          (!arb.valid || arb.prio[i] >= arb.win_prio)) begin
        arb.valid    = 1'b1;
        arb.index    = IDX_W'(i);
        arb.win_prio = arb.prio[i];
      end
    end
  end
endmodule // ictl_arb
`default_nettype wire

//--- hdl/ictl_top.sv
// Behaviour
// - Each source has a request flag set by hardware, cleared by software.
// - A source whose enable bit is clear is never forwarded to the core.
// - Every source carries a three-bit priority field, levels 0 to 7.
// - Pending winner's vector and priority latch into vector status fields.
// - Source order follows vectors; external zero is vector 8, bit 0.
// - Control one holds nesting disable plus four trap status flags.
// - Control two holds global enable and external line behaviour.
// - Core status bits 7:5 show and set low core priority bits.
// - Core priority top bit is read-only in core control register.
// - Control three bit 5 reads 1 after a DMA address error trap.
// - Control three bits 15:6 and 3:0 always read zero.
// - Control four bit 0 flags a software hard trap, clears at reset.
`timescale 1ns/1ns
`default_nettype none
module ictl_top (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            reset_n,
  // Avalon-MM slave
  input  wire logic [ictl_pkg::ADDR_W-1:0]     address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [31:0]                     writedata,
  input  wire logic [3:0]                      byteenable,
  output logic [31:0]                          readdata,
  output logic                                 waitrequest,
  // Interrupt sources
  input  wire logic [ictl_pkg::NUM_EXT-1:0]    ext_irq,
  input  wire logic [ictl_pkg::NUM_PER-1:0]    periph_req,
  input  wire logic [ictl_pkg::NUM_TRAP-1:0]   trap_evt,
  input  wire logic                            dma_addr_err,
  input  wire logic                            loop_stack_ovf,
  input  wire logic                            soft_hard_trap,
  // Processor core
  input  wire logic                            irq_ack,
  input  wire logic                            trap_level_msb,
  output logic                                 irq_req,
  output logic [7:0]                           irq_vector,
  output logic [ictl_pkg::LVL_W-1:0]           irq_level
);
  import ictl_pkg::*;

  logic                   rst_meta;
  logic                   rst_n;
  logic                   ack;
  logic [REG_W-1:0]       req_flags;
  logic [REG_W-1:0]       enables;
  logic [REG_W-1:0]       prio_reg [NUM_PREG];
  logic                   nesting_disable;
  logic [NUM_TRAP-1:0]    trap_flags;
  logic                   global_irq_enable;
  logic [NUM_EXT-1:0]     ext_falling;
  logic                   dma_addr_error_flag;
  logic                   loop_stack_overflow_flag;
  logic                   soft_hard_trap_flag;
  logic [7:0]             vector_number_field;
  ictl_lvl_t              new_priority_field;
  ictl_prio_t             core_priority_level;
  logic                   core_priority_msb;

  ictl_arb_if arb_bus ();

  // Reset is released through two flops so its removal is clean.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Bus handshake: every access waits exactly one cycle.
  wire                req_any = read | write;
  wire                wr_en   = write & ack;
  wire                rd_load = read & ~ack;
  wire [REG_W-1:0]    be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [REG_W-1:0]    wd      = writedata[REG_W-1:0];

  assign waitrequest = req_any & ~ack;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req_any & ~ack;
    end
  end

  // Address decode.
  wire sel_one   = (address == OFF_CTL_ONE);
  wire sel_two   = (address == OFF_CTL_TWO);
  wire sel_three = (address == OFF_CTL_THREE);
  wire sel_four  = (address == OFF_CTL_FOUR);
  wire sel_cstat = (address == OFF_CORE_STAT);
  wire sel_flags = (address == OFF_REQ_FLAG);
  wire sel_enab  = (address == OFF_ENABLE);

  wire [REG_W-1:0] m_flags = (req_flags & ~be_mask) | (wd & be_mask);
  wire [REG_W-1:0] m_enab  = (enables & ~be_mask) | (wd & be_mask);

  // Set events: external edges fill the low positions, peripherals above.
  logic [NUM_EXT-1:0] ext_pulse;
  wire  [NUM_PREG-1:0] prio_sel;
  wire  [REG_W-1:0]    prio_merged [NUM_PREG];
  wire  [NUM_SRC-1:0] set_vec = {periph_req, ext_pulse};

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      ictl_edge u_edge (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .pin     (ext_irq[g]),
        .falling (ext_falling[g]),
        .pulse   (ext_pulse[g])
      );
    end
    for (g = 0; g < NUM_SRC; g++) begin : g_prio
      assign arb_bus.prio[g] =
        prio_reg[g / SRC_PER_PREG][(g % SRC_PER_PREG) * PRIO_STRIDE +: PRIO_W];
    end
    for (g = 0; g < NUM_PREG; g++) begin : g_preg
      assign prio_sel[g] = (address == OFF_PRIO0 + ADDR_W'(g) * OFF_STEP);
      assign prio_merged[g] = (prio_reg[g] & ~be_mask) | (wd & be_mask);
    end
  endgenerate

  // One process owns the whole priority array, so each word has one driver.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PREG; i++) begin
        prio_reg[i] <= {4{1'b0, RST_PRIO}};
      end
    end else begin
      for (int i = 0; i < NUM_PREG; i++) begin
        if (wr_en && prio_sel[i]) begin
          prio_reg[i] <= prio_merged[i] & MASK_PRIO;
        end
      end
    end
  end

  // A hardware set in the same cycle as a software clear wins.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_flags <= RST_ZERO;
      enables   <= RST_ZERO;
    end else begin
      req_flags <= ((wr_en && sel_flags) ? m_flags : req_flags)
                   | set_vec;
      if (wr_en && sel_enab) begin
        enables <= m_enab;
      end
    end
  end

  // Control one: nesting disable and trap status flags.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nesting_disable <= 1'b0;
      trap_flags      <= '0;
    end else begin
      if (wr_en && sel_one && byteenable[1]) begin
        nesting_disable <= wd[POS_NEST_DIS];
      end
      trap_flags <= ((wr_en && sel_one && byteenable[0])
                     ? wd[NUM_TRAP-1:0] : trap_flags) | trap_evt;
    end
  end

  // Control two: global enable and edge sense of the external lines.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= RST_GLB_EN;
      ext_falling       <= '0;
    end else if (wr_en && sel_two) begin
      if (byteenable[1]) begin
        global_irq_enable <= wd[POS_GLB_EN];
      end
      if (byteenable[0]) begin
        ext_falling <= wd[NUM_EXT-1:0];
      end
    end
  end

  // Soft trap status, writable so software can clear it.
  wire wr3 = wr_en && sel_three && byteenable[0];
  wire wr4 = wr_en && sel_four && byteenable[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dma_addr_error_flag      <= 1'b0;
      loop_stack_overflow_flag <= 1'b0;
      soft_hard_trap_flag      <= 1'b0;
    end else begin
      dma_addr_error_flag <= (wr3 ? wd[POS_DMA_ERR] : dma_addr_error_flag)
                             | dma_addr_err;
      loop_stack_overflow_flag <=
        (wr3 ? wd[POS_LOOP_OVF] : loop_stack_overflow_flag)
        | loop_stack_ovf;
      soft_hard_trap_flag <= (wr4 ? wd[POS_HARD_TRAP] : soft_hard_trap_flag)
                             | soft_hard_trap;
    end
  end

  // Core priority: an acknowledge overrides a software write.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_priority_level <= '0;
      core_priority_msb   <= 1'b0;
    end else begin
      core_priority_msb <= trap_level_msb;
      if (irq_ack) begin
        core_priority_level <= nesting_disable ? LVL_NEST_MAX
                                               : new_priority_field[2:0];
      end else if (wr_en && sel_cstat && byteenable[0]) begin
        core_priority_level <= wd[POS_CORE_LVL +: PRIO_W];
      end
    end
  end

  // Arbitration inputs.
  assign arb_bus.active   = req_flags & enables
                            & {NUM_SRC{global_irq_enable}};
  assign arb_bus.core_lvl = {core_priority_msb, core_priority_level};

  ictl_arb u_arb (
    .arb (arb_bus.arb)
  );

  // Winner capture, held while nothing is pending.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vector_number_field <= '0;
      new_priority_field  <= '0;
      irq_req             <= 1'b0;
    end else begin
      irq_req <= arb_bus.valid;
      if (arb_bus.valid) begin
        vector_number_field <= VEC_BASE + 8'(arb_bus.index);
        new_priority_field  <= {1'b0, arb_bus.win_prio};
      end
    end
  end

  assign irq_vector = vector_number_field;
  assign irq_level  = new_priority_field;

  // Read mux; unmapped words read zero.
  logic [REG_W-1:0] rd_mux;
  always_comb begin
    case (address)
      OFF_CTL_ONE:   rd_mux = {nesting_disable, 11'h000, trap_flags};
      OFF_CTL_TWO:   rd_mux = {global_irq_enable, 12'h000, ext_falling};
      OFF_CTL_THREE: rd_mux = {10'h000, dma_addr_error_flag,
                               loop_stack_overflow_flag, 4'h0};
      OFF_CTL_FOUR:  rd_mux = {15'h0000, soft_hard_trap_flag};
      OFF_VEC_STAT:  rd_mux = {4'h0, new_priority_field, vector_number_field};
      OFF_CORE_STAT: rd_mux = {8'h00, core_priority_level, 5'h00};
      OFF_CORE_CTL:  rd_mux = {12'h000, core_priority_msb, 3'h0};
      OFF_REQ_FLAG:  rd_mux = req_flags;
      OFF_ENABLE:    rd_mux = enables;
      OFF_PRIO0:     rd_mux = prio_reg[0];
      8'h34:         rd_mux = prio_reg[1];
      8'h38:         rd_mux = prio_reg[2];
      8'h3C:         rd_mux = prio_reg[3];
      default:       rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (rd_load) begin
      readdata <= {16'h0000, rd_mux};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  flag_sticky_a: assert property (
    req_flags[5] && !(wr_en && sel_flags) |=> req_flags[5])
    else $error("request flag dropped without a software write");
  flag_set_a: assert property (
    periph_req[0] |=> req_flags[NUM_EXT])
    else $error("peripheral request did not set its flag");
  enable_gate_a: assert property (
    arb_bus.valid |-> enables[arb_bus.index])
    else $error("disabled source reached the core");
  prio_write_a: assert property (
    wr_en && address == OFF_PRIO0 && byteenable[0]
    |=> prio_reg[0][2:0] == $past(writedata[2:0]))
    else $error("priority field write lost");
  vec_latch_a: assert property (
    arb_bus.valid |=> irq_req
    && irq_vector == VEC_BASE + 8'($past(arb_bus.index))
    && irq_level == {1'b0, $past(arb_bus.win_prio)})
    else $error("vector status not latched from winner");
  ext_zero_a: assert property (
    ext_pulse[0] |=> req_flags[0])
    else $error("external line zero did not set bit zero");
  nest_dis_a: assert property (
    irq_ack && nesting_disable |=> core_priority_level == LVL_NEST_MAX)
    else $error("nesting disable did not raise core level");
  gie_gate_a: assert property (
    !global_irq_enable |-> !arb_bus.valid)
    else $error("request passed with global enable clear");
  ipl_write_a: assert property (
    wr_en && sel_cstat && byteenable[0] && !irq_ack
    |=> core_priority_level == $past(writedata[7:5]))
    else $error("core priority write lost");
  msb_ro_a: assert property (
    wr_en && address == OFF_CORE_CTL
    |=> core_priority_msb == $past(trap_level_msb))
    else $error("software changed core priority top bit");
  dma_err_a: assert property (
    dma_addr_err |=> dma_addr_error_flag)
    else $error("DMA address error trap not recorded");
  loop_ovf_a: assert property (
    loop_stack_ovf |=> loop_stack_overflow_flag)
    else $error("loop stack overflow trap not recorded");
  zero_bits_a: assert property (
    rd_load && sel_three |=> readdata[15:6] == 10'h000
    && readdata[3:0] == 4'h0)
    else $error("unused control three bits read nonzero");
  hard_trap_a: assert property (
    soft_hard_trap |=> soft_hard_trap_flag)
    else $error("software hard trap not recorded");
  above_core_a: assert property (
    arb_bus.valid |-> {1'b0, arb_bus.win_prio} > arb_bus.core_lvl)
    else $error("winner not above core level");

  irq_taken_c: cover property (arb_bus.valid ##1 irq_ack);
  tie_break_c: cover property (arb_bus.active[4:3] == 2'b11
                               && arb_bus.prio[3] == arb_bus.prio[4]);
  nested_c:    cover property (irq_ack && !nesting_disable
                               ##[1:20] arb_bus.valid);
endmodule // ictl_top
`default_nettype wire

//--- dv/ictl_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module ictl_core_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Bench controls
  input  wire logic       ack_on,
  input  wire logic [3:0] ack_wait,
  input  wire logic       msb_in,
  // Interrupt link
  input  wire logic       irq_req,
  output logic            irq_ack,
  output logic            trap_level_msb
);
  logic [3:0] cnt;
  logic       busy;

  // The top priority bit belongs to the core; software never sets it.
  assign trap_level_msb = msb_in;

  // One acknowledge per request, after a bench-chosen delay, so both a
  // prompt and a slow core are seen; a standing request is not re-taken.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 4'h0;
      busy    <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      if (!irq_req) begin
        busy <= 1'b0;
        cnt  <= 4'h0;
      end else if (ack_on && !busy) begin
        if (cnt == ack_wait) begin
          irq_ack <= 1'b1;
          busy    <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // ictl_core_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ictl_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  ext_irq = 3'h0;
  logic [12:0] periph_req = 13'h0;
  logic [6:0]  trig = 7'h0;
  logic        irq_ack;
  logic        trap_level_msb;
  logic        irq_req;
  logic [7:0]  irq_vector;
  logic [3:0]  irq_level;
  logic        ack_on = 1'b0;
  logic [3:0]  ack_wait = 4'h3;
  logic        msb_in = 1'b0;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] q;

  always #4 mclk = ~mclk;

  ictl_top dut (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .ext_irq(ext_irq),
    .periph_req(periph_req), .trap_evt(trig[6:3]),
    .dma_addr_err(trig[2]), .loop_stack_ovf(trig[1]),
    .soft_hard_trap(trig[0]), .irq_ack(irq_ack),
    .trap_level_msb(trap_level_msb), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level)
  );

  ictl_core_model core (
    .mclk(mclk), .rst_n(reset_n), .ack_on(ack_on), .ack_wait(ack_wait),
    .msb_in(msb_in), .irq_req(irq_req), .irq_ack(irq_ack),
    .trap_level_msb(trap_level_msb)
  );

  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge mclk);
    address   <= a;
    writedata <= {16'h0000, d};
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000);
    check(q, exp);
  endtask

  task automatic pulse(input logic [6:0] t, input logic [12:0] p);
    @(posedge mclk);
    trig       <= t;
    periph_req <= p;
    @(posedge mclk);
    trig       <= 7'h0;
    periph_req <= 13'h0;
  endtask

  // Flag to output takes one edge; four leave margin without racing.
  task automatic core_chk(input logic r, input logic [7:0] v,
                          input logic [3:0] l);
    repeat (4) @(posedge mclk);
    #1;
    check({19'h0, irq_req, irq_level, irq_vector}, {19'h0, r, l, v});
  endtask

  task automatic req_chk(input logic r);
    repeat (4) @(posedge mclk);
    #1;
    check({31'h0, irq_req}, {31'h0, r});
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(OFF_CTL_TWO, 32'h0000_8000);
    rd_chk(OFF_PRIO0, 32'h0000_4444);
    rd_chk(OFF_CTL_THREE, 32'h0);
    rd_chk(OFF_CTL_FOUR, 32'h0);
    rd_chk(OFF_REQ_FLAG, 32'h0);
    wr(8'h40, 16'hFFFF);
    rd_chk(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(8'h34, 16'(i) * 16'h1111);
      rd_chk(8'h34, {16'h0, (16'(i) * 16'h1111) & MASK_PRIO});
    end
    wr(8'h34, 16'h4444);
    wr(OFF_CTL_THREE, 16'hFFFF);
    rd_chk(OFF_CTL_THREE, 32'h0030);
    wr(OFF_CTL_THREE, 16'h0000);
    pulse(7'h04, 13'h0);
    rd_chk(OFF_CTL_THREE, 32'h0020);
    pulse(7'h02, 13'h0);
    rd_chk(OFF_CTL_THREE, 32'h0030);
    pulse(7'h01, 13'h0);
    rd_chk(OFF_CTL_FOUR, 32'h0001);
    wr(OFF_CTL_FOUR, 16'h0000);
    rd_chk(OFF_CTL_FOUR, 32'h0);
    wr(OFF_CTL_ONE, 16'h8000);
    pulse(7'h50, 13'h0);
    rd_chk(OFF_CTL_ONE, 32'h800A);
    wr(OFF_CTL_ONE, 16'h0000);
    pulse(7'h0, 13'h0001);
    req_chk(1'b0);
    rd_chk(OFF_REQ_FLAG, 32'h0008);
    wr(OFF_ENABLE, 16'h0008);
    core_chk(1'b1, 8'h0B, 4'h4);
    rd_chk(OFF_VEC_STAT, 32'h040B);
    wr(OFF_CORE_STAT, 16'h0080);
    req_chk(1'b0);
    rd_chk(OFF_CORE_STAT, 32'h0080);
    wr(OFF_CORE_STAT, 16'h0000);
    pulse(7'h0, 13'h0006);
    wr(OFF_ENABLE, 16'h0038);
    core_chk(1'b1, 8'h0B, 4'h4);
    wr(8'h34, 16'h4464);
    core_chk(1'b1, 8'h0D, 4'h6);
    wr(OFF_REQ_FLAG, 16'h0018);
    core_chk(1'b1, 8'h0B, 4'h4);
    wr(OFF_CTL_TWO, 16'h0000);
    req_chk(1'b0);
    wr(OFF_CTL_TWO, 16'h8000);
    wr(OFF_ENABLE, 16'h0009);
    @(posedge mclk);
    ext_irq <= 3'h1;
    core_chk(1'b1, 8'h08, 4'h4);
    rd_chk(OFF_REQ_FLAG, 32'h0019);
    msb_in <= 1'b1;
    rd_chk(OFF_CORE_CTL, 32'h0008);
    wr(OFF_CORE_CTL, 16'h0000);
    rd_chk(OFF_CORE_CTL, 32'h0008);
    msb_in <= 1'b0;
    ack_on <= 1'b1;
    repeat (12) @(posedge mclk);
    rd_chk(OFF_CORE_STAT, 32'h0080);
    req_chk(1'b0);
    wr(OFF_CTL_ONE, 16'h8000);
    ack_wait <= 4'h0;
    wr(OFF_CORE_STAT, 16'h0000);
    repeat (12) @(posedge mclk);
    rd_chk(OFF_CORE_STAT, 32'h00E0);
    // Line one senses falling edges: its rise must not flag, its fall must.
    wr(OFF_CTL_TWO, 16'h8002);
    @(posedge mclk);
    ext_irq <= 3'h3;
    rd_chk(OFF_REQ_FLAG, 32'h0019);
    @(posedge mclk);
    ext_irq <= 3'h1;
    rd_chk(OFF_REQ_FLAG, 32'h001B);
    test_done();
  end
endmodule // tb
`default_nettype wire
